// ---- design/rpl_csr.sv ----
// command and status registers of the preset loader
`timescale 1ns/1ps
`default_nettype none

module rpl_csr (
  input  wire logic clock,
  input  wire logic nrst,
  rpl_if.csr_mp     bus
);

  rpl_pkg::rpl_csr_t csr_q;
  rpl_pkg::rpl_csr_t csr_d;

  always_comb begin
    csr_d       = csr_q;
    csr_d.start = 1'b0;
    // a pending start also blocks, since busy lags it by one cycle
    if (bus.wr && bus.addr == rpl_pkg::OFS_LOAD && !bus.busy && !csr_q.start) begin
      csr_d.start    = 1'b1;
      csr_d.proto    = bus.wdata;
      csr_d.complete = 1'b0;
    end
    if (bus.done) begin
      csr_d.complete = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      csr_q <= rpl_pkg::CSR_RESET;
    end else begin
      csr_q <= csr_d;
    end
  end

  assign bus.start = csr_q.start;
  assign bus.proto = csr_q.proto;

  always_comb begin
    bus.csr_rdata = 8'h00;
    unique case (bus.addr)
      rpl_pkg::OFS_LOAD: begin
        bus.csr_rdata = csr_q.proto;
      end
      rpl_pkg::OFS_STATUS: begin
        bus.csr_rdata[rpl_pkg::STAT_BUSY] = bus.busy;
        bus.csr_rdata[rpl_pkg::STAT_DONE] = csr_q.complete;
      end
      rpl_pkg::OFS_INDEX: begin
        bus.csr_rdata = {3'h0, bus.idx};
      end
      default: begin
        bus.csr_rdata = 8'h00;
      end
    endcase
  end

endmodule : rpl_csr

`default_nettype wire

// ---- design/rpl_if.sv ----
// signals shared by the loader core, its control registers and its preset table
`timescale 1ns/1ps
`default_nettype none

interface rpl_if;
  logic       wr;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] csr_rdata;
  logic       start;
  logic [7:0] proto;
  logic       busy;
  logic       done;
  logic [4:0] idx;
  logic [7:0] rom_proto;
  logic [7:0] rom_data;

  modport csr_mp (input wr, addr, wdata, busy, done, idx, output start, proto, csr_rdata);
  modport rom_mp (input rom_proto, idx, output rom_data);
endinterface : rpl_if

`default_nettype wire

// ---- design/rpl_loader.sv ----
// protocol preset loader: sequencer, coding shadow and register bus front
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// ------------------------------------------------------------

module rpl_loader #(
  parameter rpl_pkg::rpl_rx_row_t P6_RX     = rpl_pkg::P6_RX_DEFAULT,
  parameter rpl_pkg::rpl_row_t    UNDEF_ROW = rpl_pkg::UNDEF_DEFAULT
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            cfg_we,
  output logic      [7:0] cfg_addr,
  output logic      [7:0] cfg_wdata,
  output logic            load_busy,
  output logic            load_done
);

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  rpl_if bus ();

  rpl_pkg::rpl_core_t core_q;
  rpl_pkg::rpl_core_t core_d;

  rpl_csr u_csr (
    .clock (clock),
    .nrst  (nrst),
    .bus   (bus)
  );

  rpl_rom #(
    .P6_RX     (P6_RX),
    .UNDEF_ROW (UNDEF_ROW)
  ) u_rom (
    .bus (bus)
  );

  assign bus.wr        = reg_wr;
  assign bus.addr      = reg_addr;
  assign bus.wdata     = reg_wdata;
  assign bus.busy      = core_q.busy;
  assign bus.done      = core_q.done;
  assign bus.idx       = core_q.idx;
  assign bus.rom_proto = core_q.proto;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    core_d       = core_q;
    core_d.we    = 1'b0;
    core_d.done  = 1'b0;
    core_d.rdata = 8'h00;
    unique case (core_q.st)
      rpl_pkg::ST_IDLE: begin
        if (bus.start) begin
          core_d.st    = rpl_pkg::ST_RUN;
          core_d.idx   = 5'h00;
          core_d.proto = bus.proto;
        end
      end
      rpl_pkg::ST_RUN: begin
        // one write per cycle, addresses confined to the coding block
        core_d.we                 = 1'b1;
        core_d.addr               = rpl_pkg::CODING_BASE + {3'h0, core_q.idx};
        core_d.wdata              = bus.rom_data;
        core_d.shadow[core_q.idx] = bus.rom_data;
        if (core_q.idx == rpl_pkg::LAST_IDX) begin
          core_d.st = rpl_pkg::ST_FIN;
        end else begin
          core_d.idx = 5'(core_q.idx + 5'h01);
        end
      end
      rpl_pkg::ST_FIN: begin
        // the last write is on the port now; report one cycle later
        core_d.done = 1'b1;
        core_d.st   = rpl_pkg::ST_IDLE;
      end
    endcase
    core_d.busy = (core_d.st != rpl_pkg::ST_IDLE);

    // ------------------------------------------------------------
    // read path: shadow of the coding block, else control registers
    // ------------------------------------------------------------
    if (reg_rd) begin
      if (reg_addr >= rpl_pkg::OFS_SHADOW &&
          reg_addr <= rpl_pkg::OFS_SHADOW + {1'b0, rpl_pkg::LAST_IDX}) begin
        core_d.rdata = core_q.shadow[5'(reg_addr - rpl_pkg::OFS_SHADOW)];
      end else begin
        core_d.rdata = bus.csr_rdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      core_q <= rpl_pkg::CORE_RESET;
    end else begin
      core_q <= core_d;
    end
  end

  assign reg_rdata = core_q.rdata;
  assign cfg_we    = core_q.we;
  assign cfg_addr  = core_q.addr;
  assign cfg_wdata = core_q.wdata;
  assign load_busy = core_q.busy;
  assign load_done = core_q.done;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  localparam logic [7:0] A_FIRST  = rpl_pkg::CODING_BASE;
  localparam logic [7:0] A_LAST   = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::LAST_IDX};
  localparam logic [7:0] A_RSV    = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_RESERVED};
  localparam logic [7:0] A_TXDC   = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_TXDC};
  localparam logic [7:0] A_TXSF   = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_TXSF};
  localparam logic [7:0] A_SYM0L  = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_SYM0L};
  localparam logic [7:0] A_SYM2   = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_SYM2};
  localparam logic [7:0] A_BURST  = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_BURST};
  localparam logic [7:0] A_S10MOD = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_S10MOD};
  localparam logic [7:0] A_S32MOD = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_S32MOD};
  localparam logic [7:0] A_RECEIVE_MODULATION  = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_RECEIVE_MODULATION};
  localparam logic [7:0] A_RECEIVE_CORRELATOR = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_RECEIVE_CORRELATOR};
  localparam logic [7:0] A_FACTORY_CALIBRATION = rpl_pkg::CODING_BASE + {3'h0, rpl_pkg::IDX_FACTORY_CALIBRATION};

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  start_to_write_a: assert property (
    bus.start && core_q.st == rpl_pkg::ST_IDLE |-> ##2 cfg_we && cfg_addr == A_FIRST)
    else $error("preset burst did not begin two cycles after the start");

  start_to_done_a: assert property (
    bus.start && core_q.st == rpl_pkg::ST_IDLE |-> ##26 load_done)
    else $error("completion not reported 26 cycles after the start");

  addr_in_block_a: assert property (
    cfg_we |-> cfg_addr >= A_FIRST && cfg_addr <= A_LAST)
    else $error("write outside the coding block");

  burst_first_a: assert property (
    $rose(cfg_we) |-> cfg_addr == A_FIRST)
    else $error("burst did not start at the first coding register");

  burst_order_a: assert property (
    cfg_we && $past(cfg_we) |-> cfg_addr == $past(cfg_addr) + 8'h01)
    else $error("coding registers written out of order");

  burst_end_a: assert property (
    $fell(cfg_we) |-> $past(cfg_addr) == A_LAST && load_done)
    else $error("burst ended early or without completion");

  done_after_last_a: assert property (
    load_done |-> !cfg_we && !load_busy && $past(cfg_we) && $past(cfg_addr) == A_LAST)
    else $error("completion reported before the last write landed");

  busy_span_a: assert property (
    cfg_we |-> load_busy || $past(load_busy))
    else $error("write issued while the loader was idle");

  ignore_busy_a: assert property (
    load_busy && !load_done |=> !bus.start)
    else $error("new command accepted while loading");

  zero_slots_a: assert property (
    cfg_we && (cfg_addr == A_RSV || cfg_addr == A_BURST ||
               cfg_addr == A_S10MOD || cfg_addr == A_S32MOD) |-> cfg_wdata == 8'h00)
    else $error("reserved or modulation slot not cleared");

  factory_calibration_a: assert property (
    cfg_we && cfg_addr == A_FACTORY_CALIBRATION && core_q.proto < 8'h07 |-> cfg_wdata == 8'hf0)
    else $error("factory calibration value wrong");

  proto0_tx_a: assert property (
    cfg_we && core_q.proto == 8'h00 && cfg_addr == A_TXDC |-> cfg_wdata == 8'h83)
    else $error("protocol 00 data control wrong");

  proto0_rx_a: assert property (
    cfg_we && core_q.proto == 8'h00 && cfg_addr == A_RECEIVE_MODULATION |-> cfg_wdata == 8'h24)
    else $error("protocol 00 receive modulation wrong");

  proto1_corr_a: assert property (
    cfg_we && core_q.proto == 8'h01 && cfg_addr == A_RECEIVE_CORRELATOR |-> cfg_wdata == 8'h40)
    else $error("protocol 01 correlator wrong");

  proto2_sym2_a: assert property (
    cfg_we && core_q.proto == 8'h02 && cfg_addr == A_SYM2 |-> cfg_wdata == 8'h81)
    else $error("protocol 02 symbol2 pattern wrong");

  proto3_freq_a: assert property (
    cfg_we && core_q.proto == 8'h03 && cfg_addr == A_TXSF |-> cfg_wdata == 8'h44)
    else $error("protocol 03 symbol frequency wrong");

  proto3_corr_a: assert property (
    cfg_we && core_q.proto == 8'h03 && cfg_addr == A_RECEIVE_CORRELATOR |-> cfg_wdata == 8'h50)
    else $error("protocol 03 correlator wrong");

  proto4_dc_a: assert property (
    cfg_we && core_q.proto == 8'h04 && cfg_addr == A_TXDC |-> cfg_wdata == 8'hc5)
    else $error("protocol 04 data control wrong");

  proto4_receive_modulation_a: assert property (
    cfg_we && core_q.proto == 8'h04 && cfg_addr == A_RECEIVE_MODULATION |-> cfg_wdata == 8'h0c)
    else $error("protocol 04 receive modulation wrong");

  proto5_corr_a: assert property (
    cfg_we && core_q.proto == 8'h05 && cfg_addr == A_RECEIVE_CORRELATOR |-> cfg_wdata == 8'h50)
    else $error("protocol 05 correlator wrong");

  proto6_sym0_a: assert property (
    cfg_we && core_q.proto == 8'h06 && cfg_addr == A_SYM0L |-> cfg_wdata == 8'h41)
    else $error("protocol 06 symbol0 low pattern wrong");

  proto0_shape_a: assert property (
    cfg_we && core_q.proto == 8'h00 && cfg_addr == A_FIRST |-> cfg_wdata == 8'h00)
    else $error("protocol 00 transmit shaping not cleared");

  proto0_freq_a: assert property (
    cfg_we && core_q.proto == 8'h00 && cfg_addr == A_TXSF |-> cfg_wdata == 8'h40)
    else $error("protocol 00 symbol frequency wrong");

  proto0_corr_a: assert property (
    cfg_we && core_q.proto == 8'h00 && cfg_addr == A_RECEIVE_CORRELATOR |-> cfg_wdata == 8'h60)
    else $error("protocol 00 correlator wrong");

  proto1_receive_modulation_a: assert property (
    cfg_we && core_q.proto == 8'h01 && cfg_addr == A_RECEIVE_MODULATION |-> cfg_wdata == 8'h24)
    else $error("protocol 01 receive modulation wrong");

  proto2_corr_a: assert property (
    cfg_we && core_q.proto == 8'h02 && cfg_addr == A_RECEIVE_CORRELATOR |-> cfg_wdata == 8'h60)
    else $error("protocol 02 correlator wrong");

  proto3_dc_a: assert property (
    cfg_we && core_q.proto == 8'h03 && cfg_addr == A_TXDC |-> cfg_wdata == 8'h44)
    else $error("protocol 03 data control wrong");

  proto3_sym0_a: assert property (
    cfg_we && core_q.proto == 8'h03 && cfg_addr == A_SYM0L |-> cfg_wdata == 8'h22)
    else $error("protocol 03 symbol0 low pattern wrong");

  proto3_receive_modulation_a: assert property (
    cfg_we && core_q.proto == 8'h03 && cfg_addr == A_RECEIVE_MODULATION |-> cfg_wdata == 8'h04)
    else $error("protocol 03 receive modulation wrong");

  proto4_shape_a: assert property (
    cfg_we && core_q.proto == 8'h04 && cfg_addr == A_FIRST |-> cfg_wdata == 8'h80)
    else $error("protocol 04 transmit shaping wrong");

  proto4_corr_a: assert property (
    cfg_we && core_q.proto == 8'h04 && cfg_addr == A_RECEIVE_CORRELATOR |-> cfg_wdata == 8'h40)
    else $error("protocol 04 correlator wrong");

  proto5_receive_modulation_a: assert property (
    cfg_we && core_q.proto == 8'h05 && cfg_addr == A_RECEIVE_MODULATION |-> cfg_wdata == 8'h0c)
    else $error("protocol 05 receive modulation wrong");

  proto6_dc_a: assert property (
    cfg_we && core_q.proto == 8'h06 && cfg_addr == A_TXDC |-> cfg_wdata == 8'hc5)
    else $error("protocol 06 data control wrong");

  supplied_rx_a: assert property (
    cfg_we && core_q.proto == rpl_pkg::PROTO_RX_SUP && cfg_addr == A_RECEIVE_CORRELATOR
      |-> cfg_wdata == P6_RX[rpl_pkg::IDX_RECEIVE_CORRELATOR[2:0]])
    else $error("protocol 06 receive value not from supplied constants");

  undef_row_a: assert property (
    cfg_we && core_q.proto >= 8'h07 |-> cfg_wdata == UNDEF_ROW[5'(cfg_addr - A_FIRST)])
    else $error("unknown protocol not loaded from supplied constants");

  shadow_match_a: assert property (
    load_done |-> core_q.shadow[rpl_pkg::IDX_FACTORY_CALIBRATION] == $past(cfg_wdata))
    else $error("shadow does not hold the last preset value");

  read_only_once_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data present outside the answer cycle");

endmodule : rpl_loader

`default_nettype wire

// ---- design/rpl_pkg.sv ----
// shared constants and types of the protocol preset loader
`default_nettype none

package rpl_pkg;

  // ------------------------------------------------------------
  // coding register block
  // ------------------------------------------------------------
  localparam int unsigned NUM_PROTO    = 7;
  localparam logic [4:0]  LAST_IDX     = 5'h17;
  localparam logic [4:0]  RX_FIRST_IDX = 5'h10;
  localparam logic [7:0]  PROTO_RX_SUP = 8'h06;
  localparam logic [7:0]  CODING_BASE  = 8'h48;

  // positions inside the coding block, in write order
  localparam logic [4:0]  IDX_RESERVED = 5'h01;
  localparam logic [4:0]  IDX_TXDC     = 5'h02;
  localparam logic [4:0]  IDX_TXSF     = 5'h04;
  localparam logic [4:0]  IDX_SYM0L    = 5'h06;
  localparam logic [4:0]  IDX_SYM2     = 5'h09;
  localparam logic [4:0]  IDX_BURST    = 5'h0d;
  localparam logic [4:0]  IDX_S10MOD   = 5'h0e;
  localparam logic [4:0]  IDX_S32MOD   = 5'h0f;
  localparam logic [4:0]  IDX_RECEIVE_MODULATION    = 5'h15;
  localparam logic [4:0]  IDX_RECEIVE_CORRELATOR   = 5'h16;
  localparam logic [4:0]  IDX_FACTORY_CALIBRATION   = 5'h17;

  // ------------------------------------------------------------
  // software register offsets
  // ------------------------------------------------------------
  localparam logic [5:0]  OFS_LOAD     = 6'h00;
  localparam logic [5:0]  OFS_STATUS   = 6'h01;
  localparam logic [5:0]  OFS_INDEX    = 6'h02;
  localparam logic [5:0]  OFS_SHADOW   = 6'h20;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_DONE    = 1;

  // ------------------------------------------------------------
  // preset table
  // ------------------------------------------------------------
  typedef logic [0:23][7:0] rpl_row_t;
  typedef logic [0:7][7:0]  rpl_rx_row_t;

  // row 6 receive half is overridden by supplied constants
  localparam rpl_row_t [0:6] PRESET_TAB = '{
    '{8'h00, 8'h00, 8'h83, 8'h04, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h84, 8'h02, 8'h00,
      8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1d, 8'h00, 8'h01, 8'h00, 8'h24, 8'h60, 8'hf0},
    '{8'h00, 8'h00, 8'h83, 8'h04, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h84, 8'h02, 8'h00,
      8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1d, 8'h00, 8'h01, 8'h00, 8'h24, 8'h40, 8'hf0},
    '{8'h00, 8'h00, 8'h83, 8'h04, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h02, 8'h00,
      8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1d, 8'h00, 8'h01, 8'h00, 8'h26, 8'h60, 8'hf0},
    '{8'h80, 8'h00, 8'h44, 8'h00, 8'h44, 8'h08, 8'h22, 8'h08, 8'h28, 8'h8a, 8'h02, 8'hbb,
      8'h37, 8'h00, 8'h00, 8'h00, 8'h08, 8'h0b, 8'h00, 8'h00, 8'h08, 8'h04, 8'h50, 8'hf0},
    '{8'h80, 8'h00, 8'hc5, 8'h00, 8'h05, 8'h68, 8'h41, 8'h01, 8'ha1, 8'h00, 8'h00, 8'h8e,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h0b, 8'h00, 8'h01, 8'h04, 8'h0c, 8'h40, 8'hf0},
    '{8'h80, 8'h00, 8'hc5, 8'h00, 8'h05, 8'h68, 8'h41, 8'h01, 8'ha1, 8'h00, 8'h00, 8'h8e,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h0b, 8'h00, 8'h01, 8'h04, 8'h0c, 8'h50, 8'hf0},
    '{8'h80, 8'h00, 8'hc5, 8'h00, 8'h05, 8'h68, 8'h41, 8'h01, 8'ha1, 8'h00, 8'h00, 8'h8e,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}
  };

  localparam rpl_rx_row_t P6_RX_DEFAULT = '{8'h08, 8'h0b, 8'h00, 8'h01, 8'h04, 8'h0c, 8'h88, 8'hf0};
  localparam rpl_row_t    UNDEF_DEFAULT = '{23: 8'hf0, default: 8'h00};

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FIN} rpl_state_t;

  typedef struct packed {
    rpl_state_t st;
    logic [4:0] idx;
    logic [7:0] proto;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       done;
    logic       busy;
    logic [7:0] rdata;
    rpl_row_t   shadow;
  } rpl_core_t;

  typedef struct packed {
    logic       start;
    logic [7:0] proto;
    logic       complete;
  } rpl_csr_t;

  localparam rpl_core_t CORE_RESET = '{st: ST_IDLE, default: '0};
  localparam rpl_csr_t  CSR_RESET  = '0;

endpackage : rpl_pkg

`default_nettype wire

// ---- design/rpl_rom.sv ----
// read-only preset table indexed by protocol number and register position
`timescale 1ns/1ps
`default_nettype none

module rpl_rom #(
  parameter rpl_pkg::rpl_rx_row_t P6_RX     = rpl_pkg::P6_RX_DEFAULT,
  parameter rpl_pkg::rpl_row_t    UNDEF_ROW = rpl_pkg::UNDEF_DEFAULT
) (
  rpl_if.rom_mp bus
);

  always_comb begin
    if (bus.rom_proto >= 8'(rpl_pkg::NUM_PROTO)) begin
      bus.rom_data = UNDEF_ROW[bus.idx];
    end else if (bus.rom_proto == rpl_pkg::PROTO_RX_SUP && bus.idx >= rpl_pkg::RX_FIRST_IDX) begin
      // receive half starts on an 8-aligned slot, so the low bits index it
      bus.rom_data = P6_RX[bus.idx[2:0]];
    end else begin
      bus.rom_data = rpl_pkg::PRESET_TAB[bus.rom_proto[2:0]][bus.idx];
    end
  end

endmodule : rpl_rom

`default_nettype wire

// ---- verification/rf_protocol_preset_loader_tb.sv ----
// self-checking bench of the protocol preset loader
`timescale 1ns/1ps
`default_nettype none

module rf_protocol_preset_loader_tb;
  // distinct correlator and shaping values prove the supplied rows are used
  localparam rpl_pkg::rpl_rx_row_t P6    = '{8'h08, 8'h0b, 8'h00, 8'h01, 8'h04, 8'h0c, 8'h99, 8'hf0};
  localparam rpl_pkg::rpl_row_t    UNDEF = '{0: 8'h5a, 23: 8'hf0, default: 8'h00};

  logic        clock;
  logic        nrst;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        cfg_we;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_wdata;
  logic        load_busy;
  logic        load_done;
  int          stray;
  int          error_cnt;
  int          samples_checked;
  logic [15:0] lf;
  logic [7:0]  exp_q [$];

  rpl_loader #(.P6_RX(P6), .UNDEF_ROW(UNDEF)) dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .load_busy(load_busy), .load_done(load_done));

  rpl_coding_model model (.clock(clock), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .stray(stray));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(posedge clock);
    chk(reg_rdata, exp);
  endtask : rd

  // ------------------------------------------------------------
  // reference rows
  // ------------------------------------------------------------
  task automatic expect_row(input logic [7:0] p);
    logic [7:0] t0 [24] = '{8'h00, 8'h00, 8'h83, 8'h04, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h84, 8'h02, 8'h00,
      8'h37, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1d, 8'h00, 8'h01, 8'h00, 8'h24, 8'h60, 8'hf0};
    logic [7:0] t3 [24] = '{8'h80, 8'h00, 8'h44, 8'h00, 8'h44, 8'h08, 8'h22, 8'h08, 8'h28, 8'h8a, 8'h02, 8'hbb,
      8'h37, 8'h00, 8'h00, 8'h00, 8'h08, 8'h0b, 8'h00, 8'h00, 8'h08, 8'h04, 8'h50, 8'hf0};
    logic [7:0] t4 [24] = '{8'h80, 8'h00, 8'hc5, 8'h00, 8'h05, 8'h68, 8'h41, 8'h01, 8'ha1, 8'h00, 8'h00, 8'h8e,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h0b, 8'h00, 8'h01, 8'h04, 8'h0c, 8'h40, 8'hf0};
    logic [7:0] r  [24];
    case (p)
      8'h00, 8'h01, 8'h02: r = t0;
      8'h03: r = t3;
      8'h04, 8'h05, 8'h06: r = t4;
      default: for (int i = 0; i < 24; i++) r[i] = UNDEF[i];
    endcase
    if (p == 8'h01) r[22] = 8'h40;
    if (p == 8'h02) begin
      r[9]  = 8'h81;
      r[21] = 8'h26;
    end
    if (p == 8'h05) r[22] = 8'h50;
    if (p == 8'h06) for (int i = 0; i < 8; i++) r[16 + i] = P6[i];
    exp_q.delete();
    foreach (r[i]) exp_q.push_back(r[i]);
  endtask : expect_row

  // one load, with a refused command driven so that it is taken at edge at+1
  task automatic load(input logic [7:0] p, input int at);
    logic [7:0] e [$];
    expect_row(p);
    e = exp_q;
    @(posedge clock);
    reg_addr  <= rpl_pkg::OFS_LOAD;
    reg_wdata <= p;
    reg_wr    <= 1'b1;
    @(posedge clock);
    for (int n = 0; n < 28; n++) begin
      reg_wr    <= (n == at);
      reg_wdata <= p ^ {lf[7:2], 2'b11};
      lf = lfsr_next(lf);
      @(posedge clock);
      chk({7'h00, load_busy}, {7'h00, (n >= 1 && n <= 25)});
      chk({7'h00, cfg_we}, {7'h00, (n >= 2 && n <= 25)});
      chk({7'h00, load_done}, {7'h00, (n == 26)});
      if (cfg_we === 1'b1) begin
        chk(cfg_addr, 8'h48 + 8'(n - 2));
        chk(cfg_wdata, exp_q.pop_front());
      end
    end
    rd(rpl_pkg::OFS_STATUS, 8'h02);
    rd(rpl_pkg::OFS_LOAD, p);
    for (int i = 0; i < 24; i++) rd(rpl_pkg::OFS_SHADOW + 6'(i), e[i]);
    rd(rpl_pkg::OFS_INDEX, {3'h0, rpl_pkg::LAST_IDX});
    for (int i = 0; i < 24; i++) chk(model.mem[8'h48 + i], e[i]);
  endtask : load

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    nrst            = 1'b0;
    reg_addr        = 6'h00;
    reg_wdata       = 8'h00;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    error_cnt       = 0;
    samples_checked = 0;
    lf              = 16'hdf8a;
    repeat (5) @(posedge clock);
    chk({cfg_we, load_busy, load_done, reg_rdata[4:0]}, 8'h00);
    nrst <= 1'b1;
    rd(rpl_pkg::OFS_STATUS, 8'h00);
    rd(rpl_pkg::OFS_SHADOW, 8'h00);
    for (int p = 0; p < 8; p++) load(8'(p), (p % 2 == 1) ? 0 : 9);
    load(lf[7:0] | 8'h08, 13);
    wr(rpl_pkg::OFS_STATUS, 8'hff);
    rd(rpl_pkg::OFS_STATUS, 8'h02);
    rd(6'h38 | {3'h0, lf[2:0]}, 8'h00);
    // reset in mid-burst must abandon the load and clear every flag
    wr(rpl_pkg::OFS_LOAD, 8'h03);
    repeat (6) @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    chk({cfg_we, load_busy, load_done, reg_rdata[4:0]}, 8'h00);
    rd(rpl_pkg::OFS_STATUS, 8'h00);
    rd(rpl_pkg::OFS_LOAD, 8'h00);
    rd(rpl_pkg::OFS_SHADOW + 6'h02, 8'h00);
    load(8'h02, 9);
    chk(8'(stray), 8'h00);
    for (int a = 8'h28; a <= 8'h39; a++) chk(model.mem[a], 8'(a) ^ 8'h5a);
    summarize();
  end

  initial begin
    repeat (4000) @(posedge clock);
    error_cnt++;
    summarize();
  end
endmodule : rf_protocol_preset_loader_tb

`default_nettype wire

// ---- verification/rpl_coding_model.sv ----
// behavioural model of the rf coding register file fed by the loader
`timescale 1ns/1ps
`default_nettype none

module rpl_coding_model (
  input  wire logic       clock,
  input  wire logic       cfg_we,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  output var  int         stray
);
  logic [7:0] mem [256];

  // ------------------------------------------------------------
  // antenna settings as host firmware leaves them
  // ------------------------------------------------------------
  initial begin
    stray = 0;
    for (int a = 0; a < 256; a++) begin
      mem[a] = 8'(a) ^ 8'h5a;
    end
  end

  // writes outside the coding block are counted, never stored
  always @(posedge clock) begin
    if (cfg_we === 1'b1) begin
      if (cfg_addr >= 8'h48 && cfg_addr <= 8'h5f) begin
        mem[cfg_addr] <= cfg_wdata;
      end else begin
        stray <= stray + 1;
      end
    end
  end
endmodule : rpl_coding_model

`default_nettype wire
